/* design/spi_flash_command_protection.sv */
// serial flash instruction decoder with block write protection
`timescale 1ns/1ps
module spi_flash_command_protection
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'h5e, // arbitrary value
   parameter logic [7:0] TYPE_CODE = 8'h3c, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'ha7 // arbitrary value
)
(
   input wire logic mclk, // core clock
   input wire logic rst, // async reset, active high
   input wire logic sck, // serial clock from host
   input wire logic ce_n, // chip select, active low
   input wire logic si, // serial data in
   output logic so, // serial data out
   output logic so_oe, // so drive enable
   input wire logic wp_n, // write protect pin, active low
   output logic [ADDR_W-1:0] rd_addr, // array read address, sck side
   input wire logic [7:0] rd_data, // array read data for rd_addr
   output logic op_req, // array program/erase start pulse
   output op_kind_e op_kind, // kind of array operation
   output logic [ADDR_W-1:0] op_addr, // array operation address
   output logic [15:0] op_wdata, // {odd byte, even byte}
   input wire logic op_done // array operation finished pulse
);
   // link side: frame counters and captured bytes
   logic frame_rst;
   logic [2:0] phase_ff;
   logic [2:0] byte_idx_ff;
   logic [6:0] shift_ff;
   logic [7:0] opcode_ff;
   logic [7:0] arg_ff [1:ARG_BYTES];
   logic [2:0] bytes_done_ff;
   logic partial_ff;
   logic frame_tog_ff;
   logic [ADDR_W-1:0] rd_ptr_ff;
   logic [1:0] id_seq_ff;
   logic [7:0] out_sr_ff;
   logic drv_ff;
   logic [7:0] stat_link;
   logic [7:0] in_byte;
   logic [2:0] start;
   // core side
   logic ce_s, wp_s, so_bit_s, drv_s, tog_s;
   logic ce_d_ff, seen_tog_ff, exec;
   logic wel_ff, lock_ff, aai_ff, busy_ff, unlock_ff, ind_ff;
   logic [3:0] bp_ff;
   logic [ADDR_W-1:0] aai_addr_ff;
   logic nxt_wel, nxt_lock, nxt_aai, nxt_unlock, nxt_ind, go;
   logic [3:0] nxt_bp;
   logic [ADDR_W-1:0] nxt_aai_addr, nxt_addr, addr_in, word_next;
   op_kind_e nxt_kind;
   logic [15:0] nxt_wdata;
   logic [7:0] status_w;

   // byte index where the answer stream of an opcode begins
   function automatic logic [2:0] stream_start(input logic [7:0] op);
      case (op)
         OP_READ: stream_start = START_READ;
         OP_FAST: stream_start = START_FAST;
         OP_STAT_RD: stream_start = START_STAT;
         OP_ID_A, OP_ID_B: stream_start = START_READ;
         OP_STD_ID: stream_start = START_STAT;
         default: stream_start = START_NONE;
      endcase
   endfunction

   // true when any byte of [a, a|m] lies in the protected top range
   function automatic logic is_prot(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] m,
                                    input logic [3:0] bp);
      logic [19:0] base;
      case (bp[2:0])
         3'h0: base = BASE_NONE;
         3'h1: base = BASE_EIGHTH;
         3'h2: base = BASE_QUARTER;
         3'h3: base = BASE_HALF;
         default: base = BASE_ALL;
      endcase
      is_prot = ({1'b0, a | m} >= base);
   endfunction

   assign frame_rst = ce_n | rst;
   assign in_byte = {shift_ff, si};
   assign start = stream_start(opcode_ff);

   // bit and byte position in the frame, cleared while deselected
   always_ff @(posedge sck or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         phase_ff <= 3'h0;
         byte_idx_ff <= 3'h0;
      end
      else
      begin
         phase_ff <= phase_ff + 3'h1;
         if (phase_ff == 3'h7 && byte_idx_ff != LEN_SAT)
            byte_idx_ff <= byte_idx_ff + 3'h1;
      end
   end

   // frame record survives select rise so the core can act on it
   always_ff @(posedge sck or posedge rst)
   begin
      if (rst)
      begin
         shift_ff <= 7'h00;
         opcode_ff <= 8'h00;
         bytes_done_ff <= 3'h0;
         partial_ff <= 1'b0;
         frame_tog_ff <= 1'b0;
         for (int i = 1; i <= ARG_BYTES; i++)
            arg_ff[i] <= 8'h00;
      end
      else
      begin
         shift_ff <= in_byte[6:0];
         partial_ff <= (phase_ff != 3'h7);
         if (phase_ff == 3'h0 && byte_idx_ff == 3'h0)
         begin
            frame_tog_ff <= ~frame_tog_ff;
            bytes_done_ff <= 3'h0;
         end
         if (phase_ff == 3'h7)
         begin
            if (byte_idx_ff != LEN_SAT)
               bytes_done_ff <= byte_idx_ff + 3'h1;
            if (byte_idx_ff == 3'h0)
               opcode_ff <= in_byte;
            else if (byte_idx_ff <= 3'(ARG_BYTES))
               arg_ff[byte_idx_ff] <= in_byte;
         end
      end
   end

   // stream pointer: loaded after the third address byte, then steps
   always_ff @(posedge sck or posedge rst)
   begin
      if (rst)
      begin
         rd_ptr_ff <= '0;
         id_seq_ff <= 2'h0;
      end
      else if (phase_ff == 3'h7 && byte_idx_ff == 3'h3)
         rd_ptr_ff <= {arg_ff[1][2:0], arg_ff[2], in_byte};
      else if (phase_ff == 3'h7 && byte_idx_ff == 3'h0)
         id_seq_ff <= 2'h0;
      else if (start != START_NONE && phase_ff == 3'h0 &&
               byte_idx_ff >= start)
      begin
         rd_ptr_ff <= rd_ptr_ff + 19'h1;
         id_seq_ff <= (id_seq_ff == STD_ID_LAST) ? 2'h0 :
                      id_seq_ff + 2'h1;
      end
   end

   assign rd_addr = rd_ptr_ff;

   // output shifter changes on falling sck, ready for the next rise
   always_ff @(negedge sck or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         out_sr_ff <= 8'h00;
         drv_ff <= 1'b0;
      end
      else if (start != START_NONE && phase_ff == 3'h0 &&
               byte_idx_ff >= start)
      begin
         drv_ff <= 1'b1;
         case (opcode_ff)
            OP_STAT_RD: out_sr_ff <= stat_link;
            OP_ID_A, OP_ID_B:
               out_sr_ff <= rd_ptr_ff[0] ? DEV_CODE : MFR_CODE;
            OP_STD_ID:
               out_sr_ff <= (id_seq_ff == 2'h0) ? MFR_CODE :
                            (id_seq_ff == 2'h1) ? TYPE_CODE : DEV_CODE;
            default: out_sr_ff <= rd_data;
         endcase
      end
      else
         out_sr_ff <= {out_sr_ff[6:0], 1'b0};
   end

   // status bits other than busy change only between frames, so per-bit sync is safe
   bit_sync #(.W(8), .RST_VAL(8'h00)) stat_sync
   (
      .clk(sck),
      .rst(rst),
      .d(status_w),
      .q(stat_link)
   );

   // pins and link levels into the core clock
   bit_sync #(.W(5), .RST_VAL(5'h18)) pin_sync
   (
      .clk(mclk),
      .rst(rst),
      .d({ce_n, wp_n, out_sr_ff[7], drv_ff, frame_tog_ff}),
      .q({ce_s, wp_s, so_bit_s, drv_s, tog_s})
   );

   // select rise of a frame that saw clocks and ended on a whole byte; the frame record is
   // static by then, the synced select acts as the handshake
   assign exec = ce_s & ~ce_d_ff & (tog_s != seen_tog_ff) &
                 ~partial_ff;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ce_d_ff <= 1'b1;
         seen_tog_ff <= 1'b0;
      end
      else
      begin
         ce_d_ff <= ce_s;
         if (ce_s & ~ce_d_ff)
            seen_tog_ff <= tog_s;
      end
   end

   // status byte assembly
   always_comb
   begin
      status_w = 8'h00;
      status_w[ST_BUSY] = busy_ff;
      status_w[ST_WEL] = wel_ff;
      status_w[ST_BP_HI:ST_BP_LO] = bp_ff;
      status_w[ST_AAI] = aai_ff;
      status_w[ST_LOCK] = lock_ff;
   end

   assign addr_in = {arg_ff[1][2:0], arg_ff[2], arg_ff[3]};
   assign word_next = aai_addr_ff + 19'h2;

   // instruction execution; nothing executes while busy, though array, id and status reads still stream
   always_comb
   begin
      nxt_wel = wel_ff;
      nxt_bp = bp_ff;
      nxt_lock = lock_ff;
      nxt_aai = aai_ff;
      nxt_unlock = unlock_ff;
      nxt_ind = ind_ff;
      nxt_aai_addr = aai_addr_ff;
      nxt_kind = op_kind;
      nxt_addr = op_addr;
      nxt_wdata = op_wdata;
      go = 1'b0;
      if (exec && !busy_ff)
      begin
         case (opcode_ff)
            OP_LATCH_SET:
               if (bytes_done_ff == LEN_CMD && !aai_ff)
                  nxt_wel = 1'b1;
            OP_LATCH_CLR:
               if (bytes_done_ff == LEN_CMD)
               begin
                  nxt_wel = 1'b0;
                  nxt_aai = 1'b0;
               end
            OP_STAT_UNLOCK:
               if (bytes_done_ff == LEN_CMD && !aai_ff)
                  nxt_unlock = 1'b1;
            OP_STAT_WR:
               if (bytes_done_ff == LEN_STAT_WR && !aai_ff)
               begin
                  if ((wel_ff | unlock_ff) && !(!wp_s && lock_ff))
                  begin
                     nxt_bp = arg_ff[1][ST_BP_HI:ST_BP_LO];
                     nxt_lock = arg_ff[1][ST_LOCK];
                  end
                  nxt_wel = 1'b0;
                  nxt_unlock = 1'b0;
               end
            OP_PROG:
               if (bytes_done_ff == LEN_PROG && !aai_ff && wel_ff &&
                   !is_prot(addr_in, '0, bp_ff))
               begin
                  go = 1'b1;
                  nxt_kind = OPK_BYTE;
                  nxt_addr = addr_in;
                  nxt_wdata = {8'h00, arg_ff[4]};
                  nxt_wel = 1'b0;
               end
            OP_SE4K, OP_BE32, OP_BE64:
               if (bytes_done_ff == LEN_ERASE && !aai_ff && wel_ff &&
                   !is_prot(addr_in, (opcode_ff == OP_SE4K) ? MASK_4K :
                            (opcode_ff == OP_BE32) ? MASK_32K : MASK_64K,
                            bp_ff))
               begin
                  go = 1'b1;
                  nxt_kind = (opcode_ff == OP_SE4K) ? OPK_SECT :
                             (opcode_ff == OP_BE32) ? OPK_BLK32 : OPK_BLK64;
                  nxt_addr = addr_in;
                  nxt_wel = 1'b0;
               end
            OP_CE_A, OP_CE_B:
               if (bytes_done_ff == LEN_CMD && !aai_ff && wel_ff &&
                   bp_ff == 4'h0)
               begin
                  go = 1'b1;
                  nxt_kind = OPK_CHIP;
                  nxt_addr = '0;
                  nxt_wel = 1'b0;
               end
            OP_WORD:
               if (!aai_ff && bytes_done_ff == LEN_WORD_FIRST && wel_ff &&
                   !is_prot(addr_in, MASK_WORD, bp_ff))
               begin
                  go = 1'b1;
                  nxt_aai = 1'b1;
                  nxt_kind = OPK_WORD;
                  nxt_addr = {addr_in[ADDR_W-1:1], 1'b0};
                  nxt_aai_addr = {addr_in[ADDR_W-1:1], 1'b0};
                  nxt_wdata = {arg_ff[5], arg_ff[4]};
               end
               else if (aai_ff && bytes_done_ff == LEN_WORD_NEXT)
               begin
                  // no wrap: top or protected word ends the sequence
                  if (word_next == '0 || is_prot(word_next, MASK_WORD, bp_ff))
                  begin
                     nxt_aai = 1'b0;
                     nxt_wel = 1'b0;
                  end
                  else
                  begin
                     go = 1'b1;
                     nxt_kind = OPK_WORD;
                     nxt_addr = word_next;
                     nxt_aai_addr = word_next;
                     nxt_wdata = {arg_ff[2], arg_ff[1]};
                  end
               end
            OP_IND_ON:
               if (bytes_done_ff == LEN_CMD && !aai_ff)
                  nxt_ind = 1'b1;
            OP_IND_OFF:
               if (bytes_done_ff == LEN_CMD && !aai_ff)
                  nxt_ind = 1'b0;
            default: ;
         endcase
      end
   end

   // status and mode flags
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wel_ff <= 1'b0;
         bp_ff <= BP_RESET;
         lock_ff <= LOCK_RESET;
         aai_ff <= 1'b0;
         unlock_ff <= 1'b0;
         ind_ff <= 1'b0;
         aai_addr_ff <= '0;
      end
      else
      begin
         wel_ff <= nxt_wel;
         bp_ff <= nxt_bp;
         lock_ff <= nxt_lock;
         aai_ff <= nxt_aai;
         unlock_ff <= nxt_unlock;
         ind_ff <= nxt_ind;
         aai_addr_ff <= nxt_aai_addr;
      end
   end

   // array operation request; busy until the array reports done
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         op_req <= 1'b0;
         op_kind <= OPK_BYTE;
         op_addr <= '0;
         op_wdata <= 16'h0000;
         busy_ff <= 1'b0;
      end
      else
      begin
         op_req <= go;
         op_kind <= nxt_kind;
         op_addr <= nxt_addr;
         op_wdata <= nxt_wdata;
         if (go)
            busy_ff <= 1'b1;
         else if (op_done)
            busy_ff <= 1'b0;
      end
   end

   // serial out: stream data first, else ready/busy in word mode;
   // lags sck fall by about three core clocks
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end
      else if (ce_s)
         so_oe <= 1'b0;
      else if (drv_s)
      begin
         so <= so_bit_s;
         so_oe <= 1'b1;
      end
      else if (ind_ff && aai_ff)
      begin
         so <= ~busy_ff;
         so_oe <= 1'b1;
      end
      else
         so_oe <= 1'b0;
   end
endmodule

/* design/flash_cmd_pkg.sv */
// opcodes, status layout and protection map for the serial flash decoder
package flash_cmd_pkg;
   localparam int ADDR_W = 19;
   localparam int ARG_BYTES = 5;
   // opcodes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_SE4K = 8'h20;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_BE64 = 8'hd8;
   localparam logic [7:0] OP_CE_A = 8'h60;
   localparam logic [7:0] OP_CE_B = 8'hc7;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_WORD = 8'had;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_UNLOCK = 8'h50;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR = 8'h04;
   localparam logic [7:0] OP_ID_A = 8'h90;
   localparam logic [7:0] OP_ID_B = 8'hab;
   localparam logic [7:0] OP_STD_ID = 8'h9f;
   localparam logic [7:0] OP_IND_ON = 8'h70;
   localparam logic [7:0] OP_IND_OFF = 8'h80;
   // status byte field positions
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_BP_LO = 2;
   localparam int ST_BP_HI = 5;
   localparam int ST_AAI = 6;
   localparam int ST_LOCK = 7;
   // power-up values
   localparam logic [3:0] BP_RESET = 4'h7;
   localparam logic LOCK_RESET = 1'b0;
   // lowest protected address, one bit wider so none can be expressed
   localparam logic [19:0] BASE_NONE = 20'h80000;
   localparam logic [19:0] BASE_EIGHTH = 20'h70000;
   localparam logic [19:0] BASE_QUARTER = 20'h60000;
   localparam logic [19:0] BASE_HALF = 20'h40000;
   localparam logic [19:0] BASE_ALL = 20'h00000;
   // span masks of the erase units and the program word
   localparam logic [18:0] MASK_WORD = 19'h00001;
   localparam logic [18:0] MASK_4K = 19'h00fff;
   localparam logic [18:0] MASK_32K = 19'h07fff;
   localparam logic [18:0] MASK_64K = 19'h0ffff;
   // whole bytes per instruction frame
   localparam logic [2:0] LEN_CMD = 3'h1;
   localparam logic [2:0] LEN_STAT_WR = 3'h2;
   localparam logic [2:0] LEN_WORD_NEXT = 3'h3;
   localparam logic [2:0] LEN_ERASE = 3'h4;
   localparam logic [2:0] LEN_PROG = 3'h5;
   localparam logic [2:0] LEN_WORD_FIRST = 3'h6;
   localparam logic [2:0] LEN_SAT = 3'h7;
   // byte index at which an output stream starts
   localparam logic [2:0] START_NONE = 3'h0;
   localparam logic [2:0] START_STAT = 3'h1;
   localparam logic [2:0] START_READ = 3'h4;
   localparam logic [2:0] START_FAST = 3'h5;
   localparam logic [1:0] STD_ID_LAST = 2'h2;
   typedef enum logic [2:0] {
      OPK_BYTE = 3'b000,
      OPK_WORD = 3'b001,
      OPK_SECT = 3'b010,
      OPK_BLK32 = 3'b011,
      OPK_BLK64 = 3'b100,
      OPK_CHIP = 3'b101
   } op_kind_e;
endpackage

/* design/bit_sync.sv */
// two-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module bit_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic clk, // destination clock
   input wire logic rst, // async reset, active high
   input wire logic [W-1:0] d, // levels from another domain
   output logic [W-1:0] q // synchronised levels
);
   logic [W-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

/* dv/flash_cmd_sva.sv */
// concurrent checks on the flash decoder ports
`timescale 1ns/1ps
module flash_cmd_sva
   import flash_cmd_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic rst, // async reset
   input wire logic sck, // serial clock
   input wire logic ce_n, // chip select
   input wire logic so, // serial out
   input wire logic so_oe, // serial out enable
   input wire logic op_req, // operation start
   input op_kind_e op_kind, // operation kind
   input wire logic [ADDR_W-1:0] op_addr // operation address
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   // nothing may start in the first cycle out of reset
   quiet_reset_a: assert property ($fell(rst) |-> !so_oe && !op_req)
      else $error("output active after reset");
   one_pulse_a: assert property (op_req |=> !op_req)
      else $error("operation start longer than one cycle");
   // array work only starts once the frame has closed
   after_deselect_a: assert property (
      op_req |-> $past(ce_n) && $past(ce_n, 2))
      else $error("operation started inside a frame");
   word_even_a: assert property (
      op_req && op_kind == OPK_WORD |-> !op_addr[0])
      else $error("word program at odd address");
   kind_legal_a: assert property (op_req |-> op_kind <= OPK_CHIP)
      else $error("unknown operation kind");
   idle_release_a: assert property (ce_n [*4] |-> !so_oe)
      else $error("serial out still driven when deselected");
   drive_selected_a: assert property (
      $rose(so_oe) |-> !ce_n && !$past(ce_n))
      else $error("serial out driven without select");
   // so moves only behind a falling serial clock, mode 0 here
   fall_drive_a: assert property (
      so_oe && $changed(so) |-> !sck && !$past(sck))
      else $error("serial out changed while clock high");
endmodule

/* dv/spi_host_model.sv */
// spi host model: mode 0 frames at a 125 ns serial clock
`timescale 1ns/1ps
module spi_host_model
(
   output logic sck, // serial clock, idle low
   output logic ce_n, // chip select, active low
   output logic si, // host data to device
   input wire logic so_line // resolved device output line
);
   initial
   begin
      sck = 1'b0;
      ce_n = 1'b1;
      si = 1'b0;
   end
   // tx bytes out msb first, nrd bytes back; cut drops the last bits
   task automatic frame(input logic [7:0] tx[$], input int nrd,
      input int cut, output logic [7:0] rx[$]);
      int n;
      logic [7:0] b;
      n = 8 * (tx.size() + nrd) - cut;
      rx = {};
      b = 8'h00;
      #1.3;
      ce_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         // filler flips every bit so no stale level is reused
         si = (i < 8 * tx.size()) ? tx[i / 8][7 - i % 8] : ~si;
         #62.5;
         sck = 1'b1;
         b = {b[6:0], so_line};
         if (i >= 8 * tx.size() && i % 8 == 7)
            rx.push_back(b);
         #62.5;
         sck = 1'b0;
      end
      #62.5;
      ce_n = 1'b1;
      si = ~si;
      #250;
   endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the flash decoder and its protection
`timescale 1ns/1ps
module testbench;
   import flash_cmd_pkg::*;
   localparam logic [7:0] MFR = 8'h21; // arbitrary value
   localparam logic [7:0] TYP = 8'h43; // arbitrary value
   localparam logic [7:0] DEV = 8'h65; // arbitrary value
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wp_n = 1'b1;
   logic op_done = 1'b0;
   logic so_last = 1'b0;
   logic sck, ce_n, si, so, so_oe, op_req;
   logic [ADDR_W-1:0] rd_addr, op_addr, op_a;
   logic [7:0] rd_data;
   logic [15:0] op_wdata, op_w;
   logic [2:0] op_k;
   op_kind_e op_kind;
   logic [9:0] done_sr = 10'h000;
   logic [7:0] rxq[$];
   int err_total = 0;
   int samples_checked = 0;
   int op_cnt = 0;
   // a released line shows the flipped last level
   wire so_line = so_oe ? so : ~so_last;
   spi_host_model spi_host_model_inst
   (
      .sck(sck), .ce_n(ce_n), .si(si), .so_line(so_line)
   );
   spi_flash_command_protection #(.MFR_CODE(MFR), .TYPE_CODE(TYP),
      .DEV_CODE(DEV)) spi_flash_command_protection_inst
   (
      .mclk(mclk), .rst(rst), .sck(sck), .ce_n(ce_n), .si(si), .so(so),
      .so_oe(so_oe), .wp_n(wp_n), .rd_addr(rd_addr), .rd_data(rd_data),
      .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr),
      .op_wdata(op_wdata), .op_done(op_done)
   );
   // array model: data is a fixed pattern of the address
   assign rd_data = rd_addr[7:0] ^ {rd_addr[18:16], 5'h0a};
   always @(so or so_oe)
      if (so_oe)
         so_last = so;
   // array work ends eleven cycles after it starts
   always @(posedge mclk)
   begin
      done_sr <= {done_sr[8:0], op_req};
      op_done <= done_sr[9];
      if (op_req === 1'b1)
      begin
         op_cnt <= op_cnt + 1;
         op_k <= op_kind;
         op_a <= op_addr;
         op_w <= op_wdata;
      end
   end
   initial
   begin
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] tx[$], input int nrd, input int cut);
      spi_host_model_inst.frame(tx, nrd, cut, rxq);
   endtask
   task automatic stat(input logic [7:0] exp);
      xfer('{OP_STAT_RD}, 1, 0);
      chk(rxq[0], exp);
   endtask
   task automatic status_write_cmd(input logic [7:0] v);
      xfer('{OP_LATCH_SET}, 0, 0);
      xfer('{OP_STAT_WR, v}, 0, 0);
   endtask
   task automatic prog(input logic [18:0] a);
      xfer('{OP_PROG, {5'h00, a[18:16]}, a[15:8], a[7:0], 8'h5a}, 0, 0);
   endtask
   task automatic s_reset();
      xfer('{OP_STAT_RD}, 2, 0);
      chk({rxq[0], rxq[1]}, 16'h1c1c);
   endtask
   task automatic s_refuse();
      xfer('{OP_LATCH_SET}, 0, 3);
      stat(8'h1c);
      xfer('{OP_LATCH_SET}, 0, 0);
      xfer('{OP_CE_A}, 0, 0);
      stat(8'h1e);
      chk(op_cnt, 0);
      xfer('{OP_STAT_UNLOCK}, 0, 0);
      xfer('{OP_STAT_WR, 8'h00}, 0, 0);
      stat(8'h00);
   endtask
   task automatic s_erase();
      logic [7:0] ops[5] = '{OP_CE_A, OP_CE_B, OP_SE4K, OP_BE32, OP_BE64};
      logic [2:0] kinds[5] = '{3'h5, 3'h5, 3'h2, 3'h3, 3'h4};
      for (int i = 0; i < 5; i++)
      begin
         xfer('{OP_LATCH_SET}, 0, 0);
         if (i < 2)
            xfer('{ops[i]}, 0, 0);
         else
            xfer('{ops[i], 8'hf9, 8'h00, 8'h00}, 0, 0);
         chk({op_cnt[7:0], op_k}, {i[7:0] + 8'h01, kinds[i]});
         if (i > 1)
            chk(op_a, 19'h10000);
      end
      xfer('{OP_PROG, 8'h00, 8'h00, 8'h12, 8'ha5}, 0, 0);
      chk(op_cnt, 5);
      xfer('{OP_LATCH_SET}, 0, 0);
      xfer('{OP_PROG, 8'hf0, 8'h00, 8'h12, 8'ha5}, 0, 0);
      chk({op_k, op_a, op_w[7:0]}, {OPK_BYTE, 19'h00012, 8'ha5});
      stat(8'h00);
   endtask
   // each range edge: first protected byte refused, byte below taken except for the whole-array setting, which has none below
   task automatic s_range();
      logic [7:0] bp[5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h24};
      logic [18:0] top[5] = '{19'h70000, 19'h60000, 19'h40000, 19'h00000,
         19'h70000};
      int n;
      n = op_cnt;
      for (int i = 0; i < 5; i++)
      begin
         status_write_cmd(bp[i]);
         xfer('{OP_LATCH_SET}, 0, 0);
         prog(top[i]);
         chk(op_cnt, n);
         if (i != 3)
         begin
            prog(top[i] - 19'h00001);
            n++;
            chk({op_cnt[7:0], op_a}, {n[7:0], top[i] - 19'h00001});
         end
      end
      stat(8'h24);
   endtask
   task automatic s_lock();
      status_write_cmd(8'h84);
      @(posedge mclk);
      wp_n <= 1'b0;
      status_write_cmd(8'h00);
      stat(8'h84);
      @(posedge mclk);
      wp_n <= 1'b1;
      status_write_cmd(8'h00);
      stat(8'h00);
   endtask
   task automatic s_read();
      xfer('{OP_READ, 8'hf7, 8'hff, 8'hfe}, 3, 0);
      chk({rxq[0], rxq[1], rxq[2]}, 24'h14150a);
      xfer('{OP_FAST, 8'h00, 8'h00, 8'h10, 8'h00}, 2, 0);
      chk({rxq[0], rxq[1]}, 16'h1a1b);
      xfer('{OP_ID_A, 8'h00, 8'h00, 8'h00}, 3, 0);
      chk({rxq[0], rxq[1], rxq[2]}, {MFR, DEV, MFR});
      xfer('{OP_ID_B, 8'h00, 8'h00, 8'h01}, 2, 0);
      chk({rxq[0], rxq[1]}, {DEV, MFR});
      xfer('{OP_STD_ID}, 4, 0);
      chk({rxq[0], rxq[1], rxq[2], rxq[3]}, {MFR, TYP, DEV, MFR});
   endtask
   task automatic s_word();
      xfer('{OP_IND_ON}, 0, 0);
      xfer('{OP_LATCH_SET}, 0, 0);
      xfer('{OP_WORD, 8'h00, 8'h01, 8'h00, 8'h11, 8'h22}, 0, 0);
      chk({op_k, op_a, op_w}, {OPK_WORD, 19'h00100, 16'h2211});
      stat(8'h42);
      // ready must be driven, a released line could also read as one
      fork
         xfer('{8'hff}, 1, 0);
         begin
            @(negedge ce_n);
            #500;
            chk({so_oe, so}, 2'h3);
         end
      join
      chk(rxq[0], 8'hff);
      xfer('{OP_WORD, 8'h33, 8'h44}, 0, 0);
      chk({op_a, op_w}, {19'h00102, 16'h4433});
      xfer('{OP_LATCH_CLR}, 0, 0);
      xfer('{OP_IND_OFF}, 0, 0);
      stat(8'h00);
   endtask
   task automatic close_out();
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (8) @(posedge mclk);
      s_reset();
      s_refuse();
      s_erase();
      s_range();
      s_lock();
      s_read();
      s_word();
      close_out();
   end
   // cut a hang well past the expected run time
   initial
   begin
      #350000;
      err_total++;
      close_out();
   end
endmodule
bind spi_flash_command_protection flash_cmd_sva flash_cmd_sva_inst
(
   .mclk(mclk), .rst(rst), .sck(sck), .ce_n(ce_n), .so(so), .so_oe(so_oe),
   .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr)
);
